// [logic/vr_protect_cfg.svh]
// Constant settings of the converter supervisor: timings, register map and reset values.
`ifndef VR_PROTECT_CFG_SVH
`define VR_PROTECT_CFG_SVH

// Clock period and the voltage code settling window.
`define CLK_PERIOD_NS        25
`define CODE_HOLD_NS         400
`define CODE_HOLD_CYCLES     ((`CODE_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Target level arithmetic in units of 0.1 mV.
`define TARGET_TOP           16'h3A98
`define TARGET_STEP          16'h007D

// Register byte offsets.
`define REG_CONTROL          12'h000
`define REG_STATUS           12'h004
`define REG_IRQ_STATUS       12'h008
`define REG_IRQ_MASK         12'h00C
`define REG_TARGET           12'h010

// Field positions of the control register.
`define CTRL_FORCE_OFF_BIT   0

// Field positions of the status register.
`define STAT_STATE_LSB       0
`define STAT_REVERSE_BIT     2
`define STAT_POWER_GOOD_BIT  3
`define STAT_THERMAL_BIT     4
`define STAT_CODE_LSB        8

// Event bit positions shared by the interrupt status and mask registers.
`define EVT_OVER_VOLTAGE     0
`define EVT_REVERSE          1
`define EVT_POWER_GOOD_LOST  2
`define EVT_THERMAL          3
`define EVT_CODE_ACCEPTED    4
`define EVT_WIDTH            5

// Reset values.
`define CONTROL_RESET        1'b0
`define IRQ_MASK_RESET       5'h00
`define CODE_RESET           7'h00

`endif

// [logic/vr_protect_pkg.sv]
// Types shared by the converter supervisor modules.
package vr_protect_pkg;

    // Supervisor operating states.
    typedef enum logic [1:0]
    {
        SHUTDOWN,
        RUNNING,
        OVER_VOLTAGE_LATCH
    } supervisor_state_type;

    // Comparator and pin flags arriving from the analog side.
    typedef struct packed
    {
        logic enable_pin;
        logic supply_start_ok;
        logic supply_lockout;
        logic core_sense_below_trip;
        logic core_sense_above_release;
        logic output_over_margin;
        logic output_over_voltage;
        logic thermal_trip;
        logic thermal_release;
    } analog_flags_type;

    // Gate drive and shutdown commands.
    typedef struct packed
    {
        logic pwm_enable;
        logic high_side_drive_enable;
        logic low_side_drive_enable;
        logic low_side_drive_phase1;
        logic low_side_drive_phase2;
        logic soft_start_discharge;
        logic power_good_delay_cap_discharge;
    } drive_cmd_type;

endpackage

// [logic/code_settle.sv]
// Voltage code synchroniser that accepts a new code only after it has held still.
`timescale 1ns/1ps
`include "vr_protect_cfg.svh"

module code_settle
#(
    parameter int WIDTH       = 7,
    parameter int HOLD_CYCLES = `CODE_HOLD_CYCLES
)
(
    // Clock and reset.
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Raw code pins.
    input  wire logic [WIDTH-1:0] code_pins,
    // Accepted code and its one-cycle update pulse.
    output logic      [WIDTH-1:0] code_accepted,
    output logic                  code_update
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] seen;
    logic [WIDTH-1:0] next_seen;
    logic [WIDTH-1:0] next_code_accepted;
    logic             next_code_update;
    logic [7:0]       hold_count;
    logic [7:0]       next_hold_count;
    logic             waiting;
    logic             next_waiting;

    // Three-flop synchroniser; only stage2 reads stage1.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage1 <= `CODE_RESET;
            stage2 <= `CODE_RESET;
            stage3 <= `CODE_RESET;
        end
        else
        begin
            stage1 <= code_pins;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A bit counts as changed once the second and third stages agree, and every
    // change restarts the settling window so bit skew is never acted on.
    always_comb
    begin
        next_seen          = seen;
        next_hold_count    = hold_count;
        next_waiting       = waiting;
        next_code_accepted = code_accepted;
        next_code_update   = 1'b0;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (stage2[i] == stage3[i])
            begin
                next_seen[i] = stage3[i];
            end
        end
        if (next_seen != seen)
        begin
            next_waiting    = 1'b1;
            next_hold_count = 8'h00;
        end
        else if (waiting)
        begin
            if (hold_count >= 8'(HOLD_CYCLES - 1))
            begin
                next_waiting       = 1'b0;
                next_code_accepted = seen;
                next_code_update   = (seen != code_accepted);
            end
            else
            begin
                next_hold_count = hold_count + 8'h01;
            end
        end
    end

    // State registers of the settling logic.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            seen          <= `CODE_RESET;
            hold_count    <= 8'h00;
            waiting       <= 1'b0;
            code_accepted <= `CODE_RESET;
            code_update   <= 1'b0;
        end
        else
        begin
            seen          <= next_seen;
            hold_count    <= next_hold_count;
            waiting       <= next_waiting;
            code_accepted <= next_code_accepted;
            code_update   <= next_code_update;
        end
    end

endmodule

// [logic/vr_protection_and_vid_decode.sv]
// Supervisor of a two-phase buck controller with an APB register file.
`timescale 1ns/1ps
`include "vr_protect_cfg.svh"

module vr_protection_and_vid_decode
#(
    parameter int CODE_WIDTH = 7
)
(
    // Clock and reset.
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave.
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Analog comparator and pin flags.
    input  wire vr_protect_pkg::analog_flags_type flags_pins,
    // Processor voltage code pins.
    input  wire logic [CODE_WIDTH-1:0] voltage_code,
    // Drive, timing and status outputs.
    output vr_protect_pkg::drive_cmd_type drive,
    output logic                       power_good_flag,
    output logic                       thermal_alarm_out,
    output logic      [15:0]           target_level,
    output logic                       irq
);

    vr_protect_pkg::analog_flags_type     sync1;
    vr_protect_pkg::analog_flags_type     sync2;
    vr_protect_pkg::analog_flags_type     sync3;
    vr_protect_pkg::analog_flags_type     flags;
    vr_protect_pkg::analog_flags_type     next_flags;
    vr_protect_pkg::supervisor_state_type state;
    vr_protect_pkg::supervisor_state_type next_state;
    vr_protect_pkg::drive_cmd_type        next_drive;
    logic                                 reverse_voltage_guard;
    logic                                 next_reverse_voltage_guard;
    logic                                 next_power_good_flag;
    logic                                 next_thermal_alarm_out;
    logic [15:0]                          next_target_level;
    logic [CODE_WIDTH-1:0]                code_accepted;
    logic                                 code_update;
    logic                                 force_off;
    logic                                 next_force_off;
    logic [`EVT_WIDTH-1:0]                irq_status;
    logic [`EVT_WIDTH-1:0]                next_irq_status;
    logic [`EVT_WIDTH-1:0]                irq_mask;
    logic [`EVT_WIDTH-1:0]                next_irq_mask;
    logic [`EVT_WIDTH-1:0]                events;
    logic                                 next_irq;
    logic [31:0]                          next_prdata;
    logic                                 next_pready;
    logic                                 next_pslverr;
    logic                                 access;
    logic                                 over_voltage_guard;

    // Maps a voltage code to its target level in 0.1 mV units, floored at zero.
    function automatic logic [15:0] code_to_target(input logic [CODE_WIDTH-1:0] code);
        logic [31:0] drop;
        drop = 32'(code) * 32'(`TARGET_STEP);
        return (drop >= 32'(`TARGET_TOP)) ? 16'h0000 : 16'(32'(`TARGET_TOP) - drop);
    endfunction

    // Tells whether an address names a mapped register.
    function automatic logic is_mapped(input logic [11:0] addr);
        return (addr == `REG_CONTROL) || (addr == `REG_STATUS) ||
               (addr == `REG_IRQ_STATUS) || (addr == `REG_IRQ_MASK) ||
               (addr == `REG_TARGET);
    endfunction

    // Voltage code settling and acceptance.
    code_settle
    #(
        .WIDTH       (CODE_WIDTH),
        .HOLD_CYCLES (`CODE_HOLD_CYCLES)
    )
    u_code_settle
    (
        .pclk          (pclk),
        .presetn       (presetn),
        .code_pins     (voltage_code),
        .code_accepted (code_accepted),
        .code_update   (code_update)
    );

    // Three-flop synchroniser for the analog flags; only sync2 reads sync1.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end
        else
        begin
            sync1 <= flags_pins;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // A flag bit takes a new level only when the second and third stages agree;
    // while they differ the bit keeps its accepted level.
    always_comb
    begin
        next_flags = (sync2 & sync3) | (flags & (sync2 | sync3));
    end

    assign access = psel && penable && !pready;
    assign over_voltage_guard = (state == vr_protect_pkg::OVER_VOLTAGE_LATCH);

    // Supervisor state, protections, flags and drive commands.
    always_comb
    begin
        next_state                 = state;
        next_drive                 = '0;
        next_reverse_voltage_guard = flags.core_sense_below_trip ||
                                     (reverse_voltage_guard && !flags.core_sense_above_release);
        case (state)
            vr_protect_pkg::SHUTDOWN:
            begin
                if (flags.supply_start_ok && flags.enable_pin &&
                    !flags.supply_lockout && !force_off)
                begin
                    next_state = vr_protect_pkg::RUNNING;
                end
            end
            vr_protect_pkg::RUNNING:
            begin
                if (flags.supply_lockout || !flags.enable_pin || force_off)
                begin
                    next_state = vr_protect_pkg::SHUTDOWN;
                end
                else if (flags.output_over_voltage)
                begin
                    next_state = vr_protect_pkg::OVER_VOLTAGE_LATCH;
                end
            end
            vr_protect_pkg::OVER_VOLTAGE_LATCH:
            begin
                if (flags.supply_lockout || !flags.enable_pin || force_off)
                begin
                    next_state = vr_protect_pkg::SHUTDOWN;
                end
            end
            default:
            begin
                next_state = vr_protect_pkg::SHUTDOWN;
            end
        endcase
        // Drives follow the state being entered, so they never lag it by a cycle.
        case (next_state)
            vr_protect_pkg::RUNNING:
            begin
                next_drive.pwm_enable             = 1'b1;
                next_drive.high_side_drive_enable = 1'b1;
                next_drive.low_side_drive_enable  = 1'b1;
            end
            vr_protect_pkg::OVER_VOLTAGE_LATCH:
            begin
                next_drive.low_side_drive_enable = 1'b1;
                next_drive.low_side_drive_phase1 = 1'b1;
                next_drive.low_side_drive_phase2 = 1'b1;
            end
            default:
            begin
                next_drive.soft_start_discharge           = 1'b1;
                next_drive.power_good_delay_cap_discharge = 1'b1;
            end
        endcase
        if (next_reverse_voltage_guard)
        begin
            next_drive[6:2] = 5'h00; // PWM, high side and every low side off.
        end
        next_power_good_flag = (next_state == vr_protect_pkg::RUNNING) &&
                               !flags.output_over_margin && !next_reverse_voltage_guard;
        next_thermal_alarm_out = flags.thermal_trip ||
                                 (thermal_alarm_out && !flags.thermal_release);
        next_target_level = code_to_target(code_accepted);
    end

    // Registers of the supervisor.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flags                 <= '0;
            state                 <= vr_protect_pkg::SHUTDOWN;
            reverse_voltage_guard <= 1'b0;
            drive                 <= '0;
            power_good_flag       <= 1'b0;
            thermal_alarm_out     <= 1'b0;
            target_level          <= `TARGET_TOP;
        end
        else
        begin
            flags                 <= next_flags;
            state                 <= next_state;
            reverse_voltage_guard <= next_reverse_voltage_guard;
            drive                 <= next_drive;
            power_good_flag       <= next_power_good_flag;
            thermal_alarm_out     <= next_thermal_alarm_out;
            target_level          <= next_target_level;
        end
    end

    // Sticky events; a new event wins over a read clear in the same cycle.
    always_comb
    begin
        events                       = '0;
        events[`EVT_OVER_VOLTAGE]    = (next_state == vr_protect_pkg::OVER_VOLTAGE_LATCH) &&
                                       !over_voltage_guard;
        events[`EVT_REVERSE]         = next_reverse_voltage_guard && !reverse_voltage_guard;
        events[`EVT_POWER_GOOD_LOST] = power_good_flag && !next_power_good_flag;
        events[`EVT_THERMAL]         = next_thermal_alarm_out && !thermal_alarm_out;
        events[`EVT_CODE_ACCEPTED]   = code_update;
        next_irq_status              = irq_status;
        if (access && !pwrite && (paddr == `REG_IRQ_STATUS))
        begin
            next_irq_status = '0;
        end
        next_irq_status = next_irq_status | events;
        next_irq        = |(next_irq_status & irq_mask);
    end

    // APB decode: one wait cycle, registered read data and error for unmapped words.
    always_comb
    begin
        next_pready    = access;
        next_pslverr   = access && !is_mapped(paddr);
        next_prdata    = 32'h0000_0000;
        next_force_off = force_off;
        next_irq_mask  = irq_mask;
        if (access && pwrite)
        begin
            if (paddr == `REG_CONTROL)
            begin
                next_force_off = pwdata[`CTRL_FORCE_OFF_BIT];
            end
            if (paddr == `REG_IRQ_MASK)
            begin
                next_irq_mask = pwdata[`EVT_WIDTH-1:0];
            end
        end
        if (access && !pwrite)
        begin
            case (paddr)
                `REG_CONTROL:
                begin
                    next_prdata[`CTRL_FORCE_OFF_BIT] = force_off;
                end
                `REG_STATUS:
                begin
                    next_prdata[`STAT_STATE_LSB +: 2]                 = state;
                    next_prdata[`STAT_REVERSE_BIT]                    = reverse_voltage_guard;
                    next_prdata[`STAT_POWER_GOOD_BIT]                 = power_good_flag;
                    next_prdata[`STAT_THERMAL_BIT]                    = thermal_alarm_out;
                    next_prdata[`STAT_CODE_LSB +: CODE_WIDTH]         = code_accepted;
                end
                `REG_IRQ_STATUS:
                begin
                    next_prdata[`EVT_WIDTH-1:0] = irq_status;
                end
                `REG_IRQ_MASK:
                begin
                    next_prdata[`EVT_WIDTH-1:0] = irq_mask;
                end
                `REG_TARGET:
                begin
                    next_prdata[15:0] = target_level;
                end
                default:
                begin
                    next_prdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // Registers of the bus slave and interrupt logic.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata     <= 32'h0000_0000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            force_off  <= `CONTROL_RESET;
            irq_mask   <= `IRQ_MASK_RESET;
            irq_status <= '0;
            irq        <= 1'b0;
        end
        else
        begin
            prdata     <= next_prdata;
            pready     <= next_pready;
            pslverr    <= next_pslverr;
            force_off  <= next_force_off;
            irq_mask   <= next_irq_mask;
            irq_status <= next_irq_status;
            irq        <= next_irq;
        end
    end

endmodule

// [tb/vr_protection_and_vid_decode_properties.sv]
// Port checker of the converter supervisor and its bind.
`timescale 1ns/1ps
module vr_protection_and_vid_decode_properties
(
    // Clock and reset.
    input wire logic                             pclk,
    input wire logic                             presetn,
    // Flags in, drives and status out.
    input wire vr_protect_pkg::analog_flags_type flags_pins,
    input wire vr_protect_pkg::drive_cmd_type    drive,
    input wire logic                             power_good_flag,
    input wire logic                             thermal_alarm_out
);
    wire logic keep_on;

    default clocking main_clock @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // The latch ends on enable low, supply loss or force_off; a reverse dip turns its drives off.
    assign keep_on = flags_pins.enable_pin && !flags_pins.supply_lockout
        && !flags_pins.core_sense_below_trip;

    // Steps of a reverse dip: held below the trip, then held in the middle band.
    sequence dip_held;
        flags_pins.core_sense_below_trip [*6];
    endsequence
    sequence middle_held;
        !flags_pins.core_sense_above_release [*6];
    endsequence

    chk_reverse_off:
    assert property (dip_held |-> drive[6:2] == 5'h00) else $error("drive on in dip");
    chk_reverse_hold:
    assert property (dip_held ##1 middle_held |-> drive[6:2] == 5'h00) else $error("early exit");
    chk_pgood_margin:
    assert property (flags_pins.output_over_margin [*3] |-> ##[1:3] !power_good_flag)
        else $error("power good kept");
    chk_crowbar_on:
    assert property (drive.pwm_enable ##0 (flags_pins.output_over_voltage && keep_on) [*3]
        |-> ##[0:3] drive[6:2] == 5'h07) else $error("no crowbar");
    chk_latch_hold:
    assert property (keep_on [*6] ##0 drive.low_side_drive_phase1 ##1 keep_on [*6]
        |-> drive.low_side_drive_phase1) else $error("latch lost");
    chk_shutdown_off:
    assert property ((!flags_pins.enable_pin || flags_pins.supply_lockout) [*6]
        |-> drive == 7'h03) else $error("not shut down");
    chk_start_gate:
    assert property ($rose(drive.pwm_enable)
        |-> flags_pins.enable_pin && flags_pins.supply_start_ok) else $error("bad start");
    chk_thermal_hold:
    assert property (flags_pins.thermal_trip [*6] ##1 !flags_pins.thermal_release [*6]
        |-> thermal_alarm_out) else $error("alarm wrong");
endmodule

bind vr_protection_and_vid_decode vr_protection_and_vid_decode_properties props
(
    .pclk(pclk), .presetn(presetn), .flags_pins(flags_pins), .drive(drive),
    .power_good_flag(power_good_flag), .thermal_alarm_out(thermal_alarm_out)
);

// [tb/power_stage_model.sv]
// Supply, power stage and sensor model that makes the comparator flags.
`timescale 1ns/1ps
module power_stage_model
(
    // Scenario settings and gate drives.
    input  wire logic                          enable_req,
    input  wire logic                          supply_up,
    input  wire logic                          output_fault,
    input  wire logic [1:0]                    sense_zone,
    input  wire logic [1:0]                    heat_zone,
    input  wire vr_protect_pkg::drive_cmd_type drive,
    // Comparator flags.
    output vr_protect_pkg::analog_flags_type   flags
);
    wire logic high;

    // A shorted stage pushes the output up until both low sides pull it down.
    assign high = output_fault && !(drive.low_side_drive_phase1 && drive.low_side_drive_phase2);

    // Zones: 0 above release, 1 middle band, 2 beyond the trip.
    assign flags = {
        enable_req, // Host owns enable.
        supply_up, !supply_up, // Supply flags agree.
        sense_zone == 2'h2, sense_zone == 2'h0, high, high,
        heat_zone == 2'h2, heat_zone == 2'h0};
endmodule

// [tb/vr_protection_and_vid_decode_tb.sv]
// Self-checking bench of the converter supervisor.
`timescale 1ns/1ps
`include "vr_protect_cfg.svh"
module vr_protection_and_vid_decode_tb;
    // Code pins beside the target level they select.
    typedef struct packed
    {
        logic [6:0]  code;
        logic [15:0] level;
    } code_row_type;
    code_row_type rows [6] = '{'{7'h01, 16'h3A1B}, '{7'h3F, 16'h1BD5}, '{7'h40, 16'h1B58},
        '{7'h77, 16'h007D}, '{7'h78, 16'h0000}, '{7'h00, 16'h3A98}};
    // Bus, pins and bench state.
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        enable_req = 1'b0, supply_up = 1'b0, output_fault = 1'b0;
    logic        pready, pslverr, irq, rerr, power_good_flag, thermal_alarm_out;
    logic [1:0]  sense_zone = 2'h0, heat_zone = 2'h0;
    logic [6:0]  voltage_code = 7'h00;
    logic [11:0] paddr = 12'h000;
    logic [15:0] target_level;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdata;
    int          errors = 0, samples_checked = 0, cycles = 0;
    vr_protect_pkg::analog_flags_type flags_pins;
    vr_protect_pkg::drive_cmd_type    drive;

    vr_protection_and_vid_decode dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flags_pins(flags_pins), .voltage_code(voltage_code), .drive(drive),
        .power_good_flag(power_good_flag), .thermal_alarm_out(thermal_alarm_out),
        .target_level(target_level), .irq(irq)
    );
    power_stage_model stage
    (
        .enable_req(enable_req), .supply_up(supply_up), .output_fault(output_fault),
        .sense_zone(sense_zone), .heat_zone(heat_zone), .drive(drive), .flags(flags_pins)
    );

    // Clock and hang guard.
    always #12.5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic expect_drive(input logic [6:0] exp);
        settle(8);
        check(32'(drive), 32'(exp));
    endtask
    // One APB transfer; holds the request until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wrap_up();
        $display("Checked %0d values, %0d mismatches.", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Table of codes, then registers, interrupts and the supervisor cases.
    initial
    begin
        settle(2);
        presetn <= 1'b1;
        settle(2);
        check(32'(drive), 32'h0000_0003);
        apb(1'b0, `REG_IRQ_MASK, 32'h0000_0000);
        check(rdata, 32'h0000_0000);
        apb(1'b1, `REG_IRQ_MASK, 32'h0000_0010);
        foreach (rows[i])
        begin
            voltage_code <= rows[i].code;
            settle(30);
            check(32'(target_level), 32'(rows[i].level));
            check(32'(irq), 32'h0000_0001);
            apb(1'b0, `REG_TARGET, 32'h0000_0000);
            check(rdata, 32'(rows[i].level));
            apb(1'b0, `REG_IRQ_STATUS, 32'h0000_0000);
            check(rdata, 32'h0000_0010);
        end
        apb(1'b1, `REG_IRQ_MASK, 32'h0000_0000);
        voltage_code <= 7'h05;
        settle(30);
        check(32'(irq), 32'h0000_0000);
        apb(1'b0, `REG_IRQ_STATUS, 32'h0000_0000);
        check(rdata, 32'h0000_0010);
        apb(1'b0, `REG_IRQ_STATUS, 32'h0000_0000);
        check(rdata, 32'h0000_0000);
        apb(1'b0, 12'h020, 32'h0000_0000);
        check({rdata[30:0], rerr}, 32'h0000_0001);
        repeat (3)
        begin
            voltage_code <= voltage_code ^ 7'h01;
            settle(8);
        end
        check(32'(target_level), 32'h0000_3827);
        settle(30);
        check(32'(target_level), 32'h0000_38A4);
        enable_req <= 1'b1;
        expect_drive(7'h03);
        supply_up <= 1'b1;
        expect_drive(7'h70);
        check(32'(power_good_flag), 32'h0000_0001);
        sense_zone <= 2'h2;
        expect_drive(7'h00);
        sense_zone <= 2'h1;
        expect_drive(7'h00);
        sense_zone <= 2'h0;
        expect_drive(7'h70);
        output_fault <= 1'b1;
        expect_drive(7'h1C);
        check(32'(power_good_flag), 32'h0000_0000);
        sense_zone <= 2'h2;
        expect_drive(7'h00);
        sense_zone <= 2'h0;
        expect_drive(7'h1C);
        enable_req <= 1'b0;
        output_fault <= 1'b0;
        expect_drive(7'h03);
        enable_req <= 1'b1;
        expect_drive(7'h70);
        apb(1'b0, `REG_STATUS, 32'h0000_0000);
        check(rdata, 32'h0000_0409);
        apb(1'b1, `REG_CONTROL, 32'h0000_0001);
        expect_drive(7'h03);
        apb(1'b0, `REG_CONTROL, 32'h0000_0000);
        check(rdata, 32'h0000_0001);
        apb(1'b1, `REG_CONTROL, 32'h0000_0000);
        expect_drive(7'h70);
        heat_zone <= 2'h2;
        settle(8);
        check(32'(thermal_alarm_out), 32'h0000_0001);
        heat_zone <= 2'h1;
        settle(8);
        check(32'(thermal_alarm_out), 32'h0000_0001);
        heat_zone <= 2'h0;
        settle(8);
        check(32'(thermal_alarm_out), 32'h0000_0000);
        presetn <= 1'b0;
        settle(2);
        presetn <= 1'b1;
        settle(2);
        check(32'(drive), 32'h0000_0003);
        wrap_up();
    end
endmodule
